// ===== hdl/glut_pkg.sv
// Constants, register map and types for the gray-level lookup table loader
`default_nettype none

package glut_pkg;

	// Bus geometry and responses
	localparam int unsigned ADDR_W = 12;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Command word fields
	localparam int unsigned CMD_CODE_MSB = 15;
	localparam int unsigned CMD_CODE_LSB = 8;
	localparam int unsigned CMD_DATA_MSB = 7;
	localparam int unsigned CMD_DATA_LSB = 0;

	// Command codes; a table entry's register index equals its code, byte address is four times it
	localparam logic [7:0] CODE_ODD_LUT_BYTE4_CMD = 8'h2A;
	localparam logic [7:0] CODE_ODD_LUT_BYTE3_CMD = 8'h2B;
	localparam logic [7:0] CODE_ODD_LUT_BYTE2_CMD = 8'h2C;
	localparam logic [7:0] CODE_ODD_LUT_BYTE1_CMD = 8'h2D;
	localparam logic [7:0] CODE_EVEN_LUT_BYTE15_CMD = 8'h2E;
	localparam logic [7:0] CODE_EVEN_LUT_BYTE14_CMD = 8'h2F;

	// Index field of a table byte address
	localparam int unsigned TAB_IDX_MSB = 9;
	localparam int unsigned TAB_IDX_LSB = 2;

	// Extra registers
	localparam logic [ADDR_W-1:0] REG_CMD_ADDR = 12'h100;
	localparam logic [ADDR_W-1:0] REG_MODE_ADDR = 12'h104;
	localparam logic [ADDR_W-1:0] REG_STATUS_ADDR = 12'h108;
	localparam int unsigned ST_PEND_BIT = 0;
	localparam int unsigned ST_ILLEGAL_BIT = 1;

	// Table slots
	localparam int unsigned NUM_SLOTS = 6;
	localparam logic [2:0] SLOT_ODD_LUT_BYTE4_CMD = 3'h0;
	localparam logic [2:0] SLOT_ODD_LUT_BYTE3_CMD = 3'h1;
	localparam logic [2:0] SLOT_ODD_LUT_BYTE2_CMD = 3'h2;
	localparam logic [2:0] SLOT_ODD_LUT_BYTE1_CMD = 3'h3;
	localparam logic [2:0] SLOT_EVEN_LUT_BYTE15_CMD = 3'h4;
	localparam logic [2:0] SLOT_EVEN_LUT_BYTE14_CMD = 3'h5;
	localparam logic [2:0] SLOT_NONE = 3'h6;
	localparam logic [7:0] TAB_RST [NUM_SLOTS] = '{8'h03, 8'h02, 8'h01, 8'h00, 8'hFF, 8'hAF};

	// Durations are entry plus one gray-step periods
	localparam int unsigned DUR_W = 9;
	localparam logic [DUR_W-1:0] DUR_ONE = 9'h001;

	typedef enum logic [1:0]
	{
		GLUT_MODE_MONO = 2'b00,
		GLUT_MODE_GRAY4 = 2'b01,
		GLUT_MODE_GRAY16 = 2'b10,
		GLUT_MODE_GRAY64 = 2'b11
	} glut_mode_e;

	localparam glut_mode_e MODE_RST = GLUT_MODE_GRAY16;

endpackage : glut_pkg

`default_nettype wire

// ===== hdl/glut_loader.sv
// AXI4-Lite loader for odd and even gray-level timing table entries
//
// Function
// - Entry value n gives n plus one periods
// - Code 2A loads odd entry 4, reset 03
// - Code 2B loads odd entry 3, reset 02
// - Code 2C loads odd entry 2, reset 01
// - Code 2D loads odd entry 1, reset 00
// - Code 2E loads even entry 15, reset FF
// - Code 2F loads even entry 14, reset AF
`default_nettype none

module glut_loader
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [glut_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [glut_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic seq_start,
	output logic [1:0] display_mode,
	output logic [glut_pkg::DUR_W-1:0] odd_level4_duration,
	output logic [glut_pkg::DUR_W-1:0] odd_level3_duration,
	output logic [glut_pkg::DUR_W-1:0] odd_level2_duration,
	output logic [glut_pkg::DUR_W-1:0] odd_level1_duration,
	output logic [glut_pkg::DUR_W-1:0] even_level15_duration,
	output logic [glut_pkg::DUR_W-1:0] even_level14_duration
);

	localparam int unsigned TAB_LOW_MSB = glut_pkg::TAB_IDX_LSB - 1;

	function automatic logic [2:0] code_slot(input logic [7:0] code);
		logic [2:0] s;
		s = glut_pkg::SLOT_NONE;
		if (code == glut_pkg::CODE_ODD_LUT_BYTE4_CMD)
			s = glut_pkg::SLOT_ODD_LUT_BYTE4_CMD;
		else if (code == glut_pkg::CODE_ODD_LUT_BYTE3_CMD)
			s = glut_pkg::SLOT_ODD_LUT_BYTE3_CMD;
		else if (code == glut_pkg::CODE_ODD_LUT_BYTE2_CMD)
			s = glut_pkg::SLOT_ODD_LUT_BYTE2_CMD;
		else if (code == glut_pkg::CODE_ODD_LUT_BYTE1_CMD)
			s = glut_pkg::SLOT_ODD_LUT_BYTE1_CMD;
		else if (code == glut_pkg::CODE_EVEN_LUT_BYTE15_CMD)
			s = glut_pkg::SLOT_EVEN_LUT_BYTE15_CMD;
		else if (code == glut_pkg::CODE_EVEN_LUT_BYTE14_CMD)
			s = glut_pkg::SLOT_EVEN_LUT_BYTE14_CMD;
		return s;
	endfunction : code_slot

	// Table byte addresses: aligned, index field equals the command code
	function automatic logic [2:0] addr_slot(input logic [glut_pkg::ADDR_W-1:0] a);
		logic [2:0] s;
		s = glut_pkg::SLOT_NONE;
		if (a[TAB_LOW_MSB:0] == '0 && a[glut_pkg::ADDR_W-1:glut_pkg::TAB_IDX_MSB+1] == '0)
			s = code_slot(a[glut_pkg::TAB_IDX_MSB:glut_pkg::TAB_IDX_LSB]);
		return s;
	endfunction : addr_slot

	function automatic logic [glut_pkg::DUR_W-1:0] to_periods(input logic [7:0] n);
		return {1'b0, n} + glut_pkg::DUR_ONE;
	endfunction : to_periods

	// Loads the current mode does not permit; host must avoid them
	function automatic logic forbidden(input logic [2:0] s, input glut_pkg::glut_mode_e m);
		logic f;
		f = 1'b0;
		case (s)
			glut_pkg::SLOT_ODD_LUT_BYTE4_CMD, glut_pkg::SLOT_EVEN_LUT_BYTE15_CMD, glut_pkg::SLOT_EVEN_LUT_BYTE14_CMD:
				f = (m != glut_pkg::GLUT_MODE_GRAY16);
			glut_pkg::SLOT_ODD_LUT_BYTE3_CMD, glut_pkg::SLOT_ODD_LUT_BYTE2_CMD:
				f = (m == glut_pkg::GLUT_MODE_GRAY64) || (m == glut_pkg::GLUT_MODE_MONO);
			glut_pkg::SLOT_ODD_LUT_BYTE1_CMD:
				f = (m == glut_pkg::GLUT_MODE_GRAY64);
			default:
				f = 1'b0;
		endcase
		return f;
	endfunction : forbidden

	logic aw_hold_q;
	logic [glut_pkg::ADDR_W-1:0] awaddr_q;
	logic w_hold_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [1:0] rresp_q;
	logic [31:0] rdata_q;
	logic do_write;
	logic do_read;
	logic tab_wr_en;
	logic [2:0] wr_slot;
	logic [7:0] wr_byte;
	logic mode_wr;
	logic st_clr;
	logic wr_err;
	logic [2:0] cmd_slot;
	glut_pkg::glut_mode_e mode_q;
	logic pend_q;
	logic illegal_q;
	logic [7:0] tab_pend_q [glut_pkg::NUM_SLOTS];
	logic [glut_pkg::DUR_W-1:0] dur_q [glut_pkg::NUM_SLOTS];

	assign s_axi_awready = !aw_hold_q;
	assign s_axi_wready = !w_hold_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = rdata_q;
	assign display_mode = mode_q;

	// Address and data may arrive in either order; both are held until the write is done
	assign do_write = aw_hold_q && w_hold_q && !bvalid_q;
	assign do_read = s_axi_arvalid && !rvalid_q;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_hold_q <= 1'b0;
			awaddr_q <= '0;
		end
		else if (s_axi_awvalid && !aw_hold_q)
		begin
			aw_hold_q <= 1'b1;
			awaddr_q <= s_axi_awaddr;
		end
		else if (do_write)
			aw_hold_q <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_hold_q <= 1'b0;
			wdata_q <= '0;
			wstrb_q <= '0;
		end
		else if (s_axi_wvalid && !w_hold_q)
		begin
			w_hold_q <= 1'b1;
			wdata_q <= s_axi_wdata;
			wstrb_q <= s_axi_wstrb;
		end
		else if (do_write)
			w_hold_q <= 1'b0;
	end

	assign cmd_slot = code_slot(wdata_q[glut_pkg::CMD_CODE_MSB:glut_pkg::CMD_CODE_LSB]);

	always_comb
	begin
		tab_wr_en = 1'b0;
		wr_slot = glut_pkg::SLOT_NONE;
		wr_byte = '0;
		mode_wr = 1'b0;
		st_clr = 1'b0;
		wr_err = 1'b0;
		if (do_write)
		begin
			if (awaddr_q == glut_pkg::REG_CMD_ADDR)
			begin
				// Whole command word needed; unknown codes are answered with an error
				if (cmd_slot == glut_pkg::SLOT_NONE)
					wr_err = 1'b1;
				else if (wstrb_q[1] && wstrb_q[0])
				begin
					tab_wr_en = 1'b1;
					wr_slot = cmd_slot;
					wr_byte = wdata_q[glut_pkg::CMD_DATA_MSB:glut_pkg::CMD_DATA_LSB];
				end
			end
			else if (addr_slot(awaddr_q) != glut_pkg::SLOT_NONE)
			begin
				tab_wr_en = wstrb_q[0];
				wr_slot = addr_slot(awaddr_q);
				wr_byte = wdata_q[glut_pkg::CMD_DATA_MSB:glut_pkg::CMD_DATA_LSB];
			end
			else if (awaddr_q == glut_pkg::REG_MODE_ADDR)
				mode_wr = wstrb_q[0];
			else if (awaddr_q == glut_pkg::REG_STATUS_ADDR)
				st_clr = wstrb_q[0] && wdata_q[glut_pkg::ST_ILLEGAL_BIT];
			else
				wr_err = 1'b1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_q <= 1'b0;
			bresp_q <= glut_pkg::RESP_OKAY;
		end
		else if (do_write)
		begin
			bvalid_q <= 1'b1;
			bresp_q <= wr_err ? glut_pkg::RESP_SLVERR : glut_pkg::RESP_OKAY;
		end
		else if (s_axi_bready)
			bvalid_q <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			mode_q <= glut_pkg::MODE_RST;
		else if (mode_wr)
			mode_q <= glut_pkg::glut_mode_e'(wdata_q[1:0]);
	end

	// Pending copies take host writes at any time
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			for (int i = 0; i < glut_pkg::NUM_SLOTS; i++)
				tab_pend_q[i] <= glut_pkg::TAB_RST[i];
		end
		else if (tab_wr_en)
			tab_pend_q[wr_slot] <= wr_byte;
	end

	// Active durations only change at a sequence start, so a line never mixes old and new
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			for (int i = 0; i < glut_pkg::NUM_SLOTS; i++)
				dur_q[i] <= to_periods(glut_pkg::TAB_RST[i]);
		end
		else if (seq_start)
		begin
			for (int i = 0; i < glut_pkg::NUM_SLOTS; i++)
				dur_q[i] <= to_periods(tab_pend_q[i]);
		end
	end

	// A write in the transfer cycle keeps the flag set: it waits for the next sequence
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			pend_q <= 1'b0;
		else if (tab_wr_en)
			pend_q <= 1'b1;
		else if (seq_start)
			pend_q <= 1'b0;
	end

	// Forbidden loads are still stored; the sticky flag lets software spot the misuse
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			illegal_q <= 1'b0;
		else if (tab_wr_en && forbidden(wr_slot, mode_q))
			illegal_q <= 1'b1;
		else if (st_clr)
			illegal_q <= 1'b0;
	end

	// Table entries and the command word are write-only and read as zero
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_q <= 1'b0;
			rresp_q <= glut_pkg::RESP_OKAY;
			rdata_q <= '0;
		end
		else if (do_read)
		begin
			rvalid_q <= 1'b1;
			rresp_q <= glut_pkg::RESP_OKAY;
			rdata_q <= '0;
			if (s_axi_araddr == glut_pkg::REG_MODE_ADDR)
				rdata_q[1:0] <= mode_q;
			else if (s_axi_araddr == glut_pkg::REG_STATUS_ADDR)
			begin
				rdata_q[glut_pkg::ST_PEND_BIT] <= pend_q;
				rdata_q[glut_pkg::ST_ILLEGAL_BIT] <= illegal_q;
			end
			else if (s_axi_araddr == glut_pkg::REG_CMD_ADDR)
				rdata_q <= '0;
			else if (addr_slot(s_axi_araddr) != glut_pkg::SLOT_NONE)
				rdata_q <= '0;
			else
				rresp_q <= glut_pkg::RESP_SLVERR;
		end
		else if (s_axi_rready)
			rvalid_q <= 1'b0;
	end

	assign odd_level4_duration = dur_q[glut_pkg::SLOT_ODD_LUT_BYTE4_CMD];
	assign odd_level3_duration = dur_q[glut_pkg::SLOT_ODD_LUT_BYTE3_CMD];
	assign odd_level2_duration = dur_q[glut_pkg::SLOT_ODD_LUT_BYTE2_CMD];
	assign odd_level1_duration = dur_q[glut_pkg::SLOT_ODD_LUT_BYTE1_CMD];
	assign even_level15_duration = dur_q[glut_pkg::SLOT_EVEN_LUT_BYTE15_CMD];
	assign even_level14_duration = dur_q[glut_pkg::SLOT_EVEN_LUT_BYTE14_CMD];

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence s_cmd_load(logic [7:0] code);
		do_write && awaddr_q == glut_pkg::REG_CMD_ADDR && wstrb_q[1:0] == 2'h3
			&& wdata_q[glut_pkg::CMD_CODE_MSB:glut_pkg::CMD_CODE_LSB] == code;
	endsequence

	sequence s_apply;
		!tab_wr_en [*2] ##1 seq_start;
	endsequence

	a_odd_lut_byte4_cmd_load: assert property (s_cmd_load(glut_pkg::CODE_ODD_LUT_BYTE4_CMD) ##1 s_apply
		|=> odd_level4_duration == to_periods($past(wdata_q[7:0], 4)))
		else $error("odd entry 4 load not applied");
	a_even_lut_byte15_cmd_load: assert property (s_cmd_load(glut_pkg::CODE_EVEN_LUT_BYTE15_CMD) ##1 s_apply
		|=> even_level15_duration == to_periods($past(wdata_q[7:0], 4)))
		else $error("even entry 15 load not applied");
	a_pend_store: assert property (tab_wr_en
		|=> tab_pend_q[$past(wr_slot)] == $past(wr_byte))
		else $error("table entry not stored");
	a_dur_stable: assert property (!seq_start |=> $stable(odd_level1_duration)
		&& $stable(odd_level2_duration) && $stable(odd_level3_duration)
		&& $stable(even_level14_duration))
		else $error("duration changed outside sequence start");
	a_reset_values: assert property (!$past(aresetn) |->
		odd_level4_duration == 9'h004 && odd_level1_duration == 9'h001
		&& even_level15_duration == 9'h100 && even_level14_duration == 9'h0B0)
		else $error("wrong reset durations");
	a_illegal_flag: assert property (tab_wr_en && wr_slot == glut_pkg::SLOT_ODD_LUT_BYTE1_CMD
		&& mode_q == glut_pkg::GLUT_MODE_GRAY64 |=> illegal_q)
		else $error("illegal load not flagged");
	a_legal_gray16: assert property (tab_wr_en && mode_q == glut_pkg::GLUT_MODE_GRAY16
		&& !illegal_q && !st_clr |=> !illegal_q)
		else $error("legal load flagged");
	a_write_only: assert property (do_read && addr_slot(s_axi_araddr) != glut_pkg::SLOT_NONE
		|=> rvalid_q && rdata_q == 32'h0000_0000 && rresp_q == glut_pkg::RESP_OKAY)
		else $error("table entry readable");
	a_bresp_hold: assert property (bvalid_q && !s_axi_bready |=> bvalid_q && $stable(bresp_q))
		else $error("write response dropped");
	a_write_answer: assert property (do_write |=> bvalid_q)
		else $error("write not answered");

endmodule : glut_loader

`default_nettype wire

// ===== testbench/glut_host.sv
// Host model: AXI4-Lite master sending table bytes and command words
`default_nettype none
module glut_host
(
	input wire logic aclk,
	output logic [glut_pkg::ADDR_W-1:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0] s_axi_wstrb,
	output logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready,
	output logic [glut_pkg::ADDR_W-1:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		s_axi_awaddr = '0;
		s_axi_awvalid = 1'b0;
		s_axi_wdata = '0;
		s_axi_wstrb = 4'hF;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_araddr = '0;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
	end
	// Mode codes: 0 mono, 1 four-level, 2 sixteen-level, 3 sixty-four-level
	function automatic logic allowed(input logic [1:0] m, input logic [7:0] c);
		case (c)
			8'h2B, 8'h2C: return m == 2'h1 || m == 2'h2;
			8'h2D: return m != 2'h3;
			default: return m == 2'h2;
		endcase
	endfunction : allowed
	task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end
		while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		// Released payload is scrambled so a stale value cannot be relied on
		s_axi_awaddr <= ~a;
		s_axi_wdata <= ~d;
		@(posedge aclk);
	endtask : wr
	task automatic cmd(input logic [7:0] c, input logic [7:0] d, output logic [1:0] r);
		wr(glut_pkg::REG_CMD_ADDR, {16'h0, c, d}, r);
	endtask : cmd
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end
		while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		s_axi_araddr <= ~a;
		@(posedge aclk);
	endtask : rd
endmodule : glut_host
`default_nettype wire

// ===== testbench/testbench.sv
// Self-checking bench for the gray-level table loader
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] CODES [6] = '{8'h2A, 8'h2B, 8'h2C, 8'h2D, 8'h2E, 8'h2F};
	localparam logic [8:0] RST [6] = '{9'h003, 9'h002, 9'h001, 9'h000, 9'h0FF, 9'h0AF};
	localparam logic [8:0] VAL [6] = '{9'h000, 9'h07F, 9'h0FF, 9'h010, 9'h080, 9'h001};
	logic aclk, aresetn, seq_start;
	logic [glut_pkg::ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, display_mode;
	logic [8:0] dur [6];
	int n_errors = 0;
	int n_tests = 0;
	int cycles = 0;
	glut_host i_host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);
	glut_loader i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .seq_start, .display_mode,
		.odd_level4_duration(dur[0]), .odd_level3_duration(dur[1]),
		.odd_level2_duration(dur[2]), .odd_level1_duration(dur[3]),
		.even_level15_duration(dur[4]), .even_level14_duration(dur[5]));
	initial
	begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	task automatic end_sim;
		$display("Comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_sim
	always @(posedge aclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_errors++;
			end_sim();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// New durations land on the same edge that samples the pulse
	task automatic pulse;
		seq_start <= 1'b1;
		@(posedge aclk);
		seq_start <= 1'b0;
		@(posedge aclk);
		@(posedge aclk);
	endtask : pulse
	task automatic s_reset;
		chk(display_mode, 32'h2);
		for (int i = 0; i < 6; i++)
			chk(dur[i], RST[i] + 9'h001);
	endtask : s_reset
	task automatic s_table;
		logic [1:0] r;
		logic [31:0] d;
		for (int i = 0; i < 6; i++)
		begin
			i_host.wr({2'b00, CODES[i], 2'b00}, {23'h0, VAL[i]}, r);
			chk(r, 32'h0);
			chk(dur[i], RST[i] + 9'h001);
			i_host.rd({2'b00, CODES[i], 2'b00}, d, r);
			chk(d, 32'h0);
		end
		pulse();
		for (int i = 0; i < 6; i++)
			chk(dur[i], VAL[i] + 9'h001);
	endtask : s_table
	task automatic s_bad;
		logic [1:0] r;
		logic [31:0] d;
		i_host.cmd(8'h30, 8'h12, r);
		chk(r, glut_pkg::RESP_SLVERR);
		i_host.wr(12'hFFC, 32'h1, r);
		chk(r, glut_pkg::RESP_SLVERR);
		i_host.rd(12'hFFC, d, r);
		chk(r, glut_pkg::RESP_SLVERR);
		pulse();
		for (int i = 0; i < 6; i++)
			chk(dur[i], VAL[i] + 9'h001);
	endtask : s_bad
	// Every load in every mode; forbidden ones only raise the sticky flag
	task automatic s_mode;
		logic [1:0] r;
		logic [31:0] d;
		for (int m = 0; m < 4; m++)
			for (int i = 0; i < 6; i++)
			begin
				i_host.wr(glut_pkg::REG_STATUS_ADDR, 32'h2, r);
				i_host.wr(glut_pkg::REG_MODE_ADDR, m, r);
				chk(display_mode, m);
				i_host.cmd(CODES[i], 8'h55, r);
				i_host.rd(glut_pkg::REG_STATUS_ADDR, d, r);
				chk(d, {30'h0, !i_host.allowed(m[1:0], CODES[i]), 1'b1});
			end
		pulse();
		i_host.rd(glut_pkg::REG_STATUS_ADDR, d, r);
		chk(d[0], 32'h0);
		for (int i = 0; i < 6; i++)
			chk(dur[i], 9'h056);
	endtask : s_mode
	// Command words applied at the very next sequence; a half-strobed command stores nothing
	task automatic s_cmd;
		logic [1:0] r;
		i_host.wr(glut_pkg::REG_MODE_ADDR, 32'h2, r);
		chk(display_mode, 32'h2);
		i_host.cmd(8'h2A, 8'h7F, r);
		chk(r, glut_pkg::RESP_OKAY);
		pulse();
		chk(dur[0], 9'h080);
		i_host.cmd(8'h2E, 8'hFF, r);
		chk(r, glut_pkg::RESP_OKAY);
		pulse();
		chk(dur[4], 9'h100);
		i_host.s_axi_wstrb <= 4'h1;
		i_host.cmd(8'h2F, 8'h00, r);
		chk(r, glut_pkg::RESP_OKAY);
		i_host.s_axi_wstrb <= 4'hF;
		pulse();
		chk(dur[5], 9'h056);
	endtask : s_cmd
	initial
	begin
		aresetn = 1'b0;
		seq_start = 1'b0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		s_reset();
		s_table();
		s_bad();
		s_mode();
		s_cmd();
		end_sim();
	end
endmodule : testbench
`default_nettype wire
